// ---- design/prp_map.svh ----
// Function
// - Reset low returns every internal register to its initial value.
// - Reset is held low for at least 1 us, then a full sequence runs.
// - Every reset captures the strap options afresh.
// - The shared pin changes function only on a register write.
// - After reset the shared pin acts as the sleep input.
// - In sleep mode a low on the shared pin powers the device down.
// - In interrupt mode the pin is pulled low on an event, never high.
// - A write to the regulator-control register sets the regulator off state from data bit 0: a 1 shuts it off, a 0 turns it on.
`ifndef PRP_MAP_SVH
`define PRP_MAP_SVH
`define PRP_CLK_PERIOD_NS   20
`define PRP_RST_MIN_NS      1000
`define PRP_RST_MIN_CYC     ((`PRP_RST_MIN_NS + `PRP_CLK_PERIOD_NS - 1) / `PRP_CLK_PERIOD_NS)
`define PRP_CNT_W           6
`define PRP_STRAP_W         8
`define PRP_STRAP_RST       8'h00
`define PRP_REG_REGCTL      16'h00D0
`define PRP_REG_PINCFG      16'h0011
`define PRP_PINCFG_MODE_BIT 0
`define PRP_REGCTL_OFF_BIT  0
`endif

// ---- design/prp_pkg.sv ----
package prp_pkg;
    typedef enum logic [1:0] {
        PRP_ST_HOLD   = 2'b00,
        PRP_ST_STRAP  = 2'b01,
        PRP_ST_RUN    = 2'b11
    } prp_state_t;

    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [15:0] data;
    } prp_wr_t;

    typedef struct packed {
        logic in;
        logic out;
        logic oe_n;
    } prp_pin_t;
endpackage

// ---- design/prp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module prp_sync (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // Level
    input  wire logic d,
    output logic      q
);
    logic meta_reg;

    // Second stage alone reads the first
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= 1'b1;
            q        <= 1'b1;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ---- design/prp_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "prp_map.svh"
module prp_top (
    // Clock and asynchronous reset
    input  wire logic                    mclk,
    input  wire logic                    resetn,
    // Strap pins sampled at reset
    input  wire logic [`PRP_STRAP_W-1:0] strap_pins,
    // Internal register write port
    input  wire prp_pkg::prp_wr_t        reg_wr,
    // Interrupt source from the rest of the device
    input  wire logic                    irq_event,
    // Shared pin, open drain
    input  wire logic                    shared_irq_sleep_pin_in,
    output logic                         shared_irq_sleep_pin_out,
    output logic                         shared_irq_sleep_pin_oe_n,
    // Status
    output logic                         core_ready,
    output logic                         power_down,
    output logic                         regulator_off,
    output logic                         irq_mode,
    output logic [`PRP_STRAP_W-1:0]      strap_cfg
);
    import prp_pkg::*;

    localparam logic [`PRP_CNT_W-1:0] RST_CYC = `PRP_CNT_W'(`PRP_RST_MIN_CYC);

    prp_state_t              state_reg;
    logic [`PRP_CNT_W-1:0]   hold_cnt_reg;
    logic                    pin_sync;
    logic                    in_run;

    prp_sync u_pin_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .d      (shared_irq_sleep_pin_in),
        .q      (pin_sync)
    );

    assign in_run = (state_reg == PRP_ST_RUN);

    // Internal registers clear while reset is low
    // Sequence: count 1 us after release, then recapture straps
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg    <= PRP_ST_HOLD;
            hold_cnt_reg <= '0;
        end else begin
            case (state_reg)
                PRP_ST_HOLD: begin
                    if (hold_cnt_reg >= RST_CYC - `PRP_CNT_W'(1)) begin
                        state_reg <= PRP_ST_STRAP;
                    end else begin
                        hold_cnt_reg <= hold_cnt_reg + `PRP_CNT_W'(1);
                    end
                end
                PRP_ST_STRAP: begin
                    state_reg <= PRP_ST_RUN;
                end
                PRP_ST_RUN: begin
                    state_reg <= PRP_ST_RUN;
                end
                default: begin
                    state_reg <= PRP_ST_HOLD;
                end
            endcase
        end
    end

    // Straps taken fresh on every reset, after release
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            strap_cfg <= `PRP_STRAP_RST;
        end else if (state_reg == PRP_ST_STRAP) begin
            strap_cfg <= strap_pins;
        end
    end

    // Pin function changes only by a register write
    // Default after reset is sleep input
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_mode <= 1'b0;
        end else if (in_run && reg_wr.wr &&
                     reg_wr.addr == `PRP_REG_PINCFG) begin
            irq_mode <= reg_wr.data[`PRP_PINCFG_MODE_BIT];
        end
    end

    // Regulator shut down by software write
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regulator_off <= 1'b0;
        end else if (in_run && reg_wr.wr &&
                     reg_wr.addr == `PRP_REG_REGCTL) begin
            regulator_off <= reg_wr.data[`PRP_REGCTL_OFF_BIT];
        end
    end

    // Low on the pin in sleep mode powers down
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            power_down <= 1'b0;
        end else begin
            power_down <= in_run && !irq_mode && !pin_sync;
        end
    end

    // Drive low only, released during reset and sequence
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            shared_irq_sleep_pin_oe_n <= 1'b1;
            shared_irq_sleep_pin_out  <= 1'b0;
        end else begin
            shared_irq_sleep_pin_oe_n <= !(in_run && irq_mode && irq_event);
            shared_irq_sleep_pin_out  <= 1'b0;
        end
    end

    // Ready only after a full minimum-width sequence
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            core_ready <= 1'b0;
        end else begin
            core_ready <= in_run;
        end
    end
endmodule
`default_nettype wire

// ---- verification/prp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module prp_host (
    // Device side
    input  wire logic shared_irq_sleep_pin_oe_n,
    // Host side
    input  wire logic sleep_req,
    output logic      shared_irq_sleep_pin_in
);
    // Wired low: either party pulls, the pull-up wins when both release
    assign shared_irq_sleep_pin_in = shared_irq_sleep_pin_oe_n && !sleep_req;
endmodule
`default_nettype wire

// ---- verification/prp_chk_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module prp_chk (
    // Clock and reset
    input wire logic             mclk,
    input wire logic             resetn,
    // Stimulus
    input wire prp_pkg::prp_wr_t reg_wr,
    input wire logic             irq_event,
    input wire logic             shared_irq_sleep_pin_in,
    // Results
    input wire logic             shared_irq_sleep_pin_out,
    input wire logic             shared_irq_sleep_pin_oe_n,
    input wire logic             core_ready,
    input wire logic             power_down,
    input wire logic             regulator_off,
    input wire logic             irq_mode
);
    wire logic oe_n = shared_irq_sleep_pin_oe_n;
    wire logic wr_ok = reg_wr.wr && core_ready;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Must hold while reset is low, so no disable
    reset_clear_a: assert property (disable iff (1'b0)
        !resetn |-> oe_n && !core_ready && !power_down && !regulator_off
        && !irq_mode) else $error("outputs not cleared in reset");
    ready_time_a: assert property ($rose(resetn) |->
        ##[50:56] $rose(core_ready)) else $error("reset sequence length");
    never_high_a: assert property (!shared_irq_sleep_pin_out)
        else $error("pin driven high");
    sleep_idle_a: assert property (!irq_mode && !$past(irq_mode)
        |-> oe_n) else $error("pin pulled in sleep mode");
    irq_follow_a: assert property (irq_mode && $past(irq_mode)
        |-> oe_n == !$past(irq_event)) else $error("irq output wrong");
    sleep_entry_a: assert property ($past(core_ready, 3) && !irq_mode
        && !$past(irq_mode, 3) && !$past(irq_mode) |-> power_down ==
        !$past(shared_irq_sleep_pin_in, 3)) else $error("power down wrong");
    mode_write_a: assert property (wr_ok && reg_wr.addr == 16'h0011
        |=> irq_mode == $past(reg_wr.data[0])) else $error("pin mode wrong");
    reg_write_a: assert property (wr_ok && reg_wr.addr == 16'h00D0
        |=> regulator_off == $past(reg_wr.data[0])) else $error("reg wrong");
    cover property (irq_mode && !oe_n);
    cover property ($rose(power_down));
    cover property ($rose(regulator_off));
endmodule
bind prp_top prp_chk u_chk (.*);
`default_nettype wire

// ---- verification/test_phy_reset_powerdown_irq_pin.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "prp_map.svh"
module test_phy_reset_powerdown_irq_pin;
    import prp_pkg::*;
    logic mclk = 0, resetn = 1, irq_event = 0, sleep_req = 0;
    logic shared_irq_sleep_pin_in, shared_irq_sleep_pin_out;
    logic shared_irq_sleep_pin_oe_n, core_ready, power_down;
    logic regulator_off, irq_mode;
    logic [7:0] strap_pins = 8'h00, strap_cfg, s;
    prp_wr_t reg_wr = '0;
    logic [13:0] e, o, prev = 14'h0001, q[$];
    int err_count = 0, checked = 0;
    always #10 mclk = ~mclk;
    assign o = {shared_irq_sleep_pin_out, core_ready, strap_cfg,
        regulator_off, irq_mode, power_down, shared_irq_sleep_pin_oe_n};
    prp_host i_host (.*);
    prp_top i_dut (.*);
    task automatic cmp(logic [13:0] x, y);
        checked++;
        if (y !== x) begin
            err_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, x, y);
        end
    endtask
    task automatic note(int i, logic v);
        e[i] = v;
        q.push_back(e);
    endtask
    task automatic step(int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr(logic [15:0] a, logic d);
        @(negedge mclk) reg_wr = {1'b1, a, 15'($urandom), d};
        @(negedge mclk) reg_wr.wr = 0;
        step(4);
    endtask
    task automatic rst();
        if (e[12] === 1'b1) q.push_back(14'h0001);
        // Scheduled so the design sees a real falling edge at time zero
        resetn <= 1'b0;
        s = 8'($urandom) | 8'h01;
        strap_pins = s;
        step(`PRP_RST_MIN_CYC);
        resetn = 1;
        e = {2'b00, s, 4'h1};
        q.push_back(e);
        note(12, 1);
        step(60);
    endtask
    task automatic nap(logic act);
        if (act) note(1, 1);
        sleep_req = 1;
        step(6);
        if (act) note(1, 0);
        sleep_req = 0;
        step(6);
    endtask
    task automatic test_done();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Results are matched in order of appearance, not by cycle
    always @(negedge mclk) if (o !== prev) begin
        cmp(q.pop_front(), o);
        prev = o;
    end
    initial begin
        #50000;
        cmp(14'h1, 14'h0);
        test_done();
    end
    initial begin
        void'($urandom(53));
        rst();
        $display("reset test done");
        note(3, 1);
        wr(16'h00D0, 1);
        wr(16'h0012, 1);
        nap(1);
        note(2, 1);
        wr(16'h0011, 1);
        nap(0);
        repeat (3) begin
            note(0, 0);
            irq_event = 1;
            step(2 + $urandom % 4);
            note(0, 1);
            irq_event = 0;
            step(4);
        end
        note(2, 0);
        wr(16'h0011, 0);
        $display("mode test done");
        rst();
        nap(1);
        note(3, 1);
        wr(16'h00D0, 1);
        note(3, 0);
        wr(16'h00D0, 0);
        $display("rerun test done");
        cmp(14'h0, 14'(q.size()));
        test_done();
    end
endmodule
`default_nettype wire
